/* File: rtl/diq_slot_port.sv */
`timescale 1ns/100ps
module diq_slot_port #(
   parameter bit ENABLE = 1'b1,
   parameter int WRITE_LATENCY = diq_pkg::WRITE_LATENCY_DEF
) (
   input wire logic sys_clk,
   input wire logic srst,
   // frame side, receive: extracted slot bytes
   input wire logic [3:0] frm_rx_lane_flags,
   input wire logic [31:0] frm_rx_word,
   output logic frm_rx_ready,
   // frame side, transmit: slot schedule and inserted bytes
   input wire logic [3:0] frm_tx_slot_lanes,
   output logic [3:0] frm_tx_lane_flags,
   output logic [31:0] frm_tx_word,
   // user side
   output logic [3:0] rx_sample_lane_flags,
   output logic [31:0] rx_sample_word,
   input wire logic rx_sample_ready,
   output logic [3:0] tx_sample_lane_accept,
   input wire logic [3:0] tx_sample_lane_flags,
   input wire logic [31:0] tx_sample_word
);
   // ==========================================================
   // receive path: two-entry buffer whose first entry is the output register
   // itself, so a stalled user loses no word and the outputs stay flops
   logic [3:0] hold_flags_reg;
   logic [31:0] hold_word_reg;
   logic [1:0] buf_cnt_reg;
   logic [1:0] cnt_next;
   logic in_fire;
   logic out_fire;

   // a word is offered whenever any lane flag is set
   assign in_fire = ENABLE && (frm_rx_lane_flags != diq_pkg::LANES_NONE) && frm_rx_ready;
   // an empty output shows zero flags, so nonzero flags mean a word is held
   assign out_fire = (rx_sample_lane_flags != diq_pkg::LANES_NONE) && rx_sample_ready;
   assign cnt_next = buf_cnt_reg + {1'b0, in_fire} - {1'b0, out_fire};

   // every port flop runs on sys_clk alone
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         buf_cnt_reg <= 2'h0;
      end else begin
         buf_cnt_reg <= cnt_next;
      end
   end

   // second entry only fills while the output entry is occupied and stays
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         hold_flags_reg <= diq_pkg::LANES_NONE;
         hold_word_reg <= diq_pkg::WORD_ZERO;
      end else if (in_fire && cnt_next == 2'h2) begin
         hold_flags_reg <= frm_rx_lane_flags;
         hold_word_reg <= frm_rx_word;
      end
   end

   // ready is registered from the next count, so it never admits a third word
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         frm_rx_ready <= 1'b0;
      end else begin
         frm_rx_ready <= ENABLE && (cnt_next < 2'(diq_pkg::BUF_DEPTH));
      end
   end

   // output entry: refilled from the second entry first, keeping word order
   always_ff @(posedge sys_clk) begin
      if (srst || !ENABLE) begin
         rx_sample_lane_flags <= diq_pkg::LANES_NONE;
         rx_sample_word <= diq_pkg::WORD_ZERO;
      end else if (out_fire || buf_cnt_reg == 2'h0) begin
         if (buf_cnt_reg == 2'h2) begin
            rx_sample_lane_flags <= hold_flags_reg;
            rx_sample_word <= hold_word_reg;
         end else if (in_fire) begin
            rx_sample_lane_flags <= frm_rx_lane_flags;
            rx_sample_word <= frm_rx_word;
         end else begin
            rx_sample_lane_flags <= diq_pkg::LANES_NONE;
            rx_sample_word <= diq_pkg::WORD_ZERO;
         end
      end
   end

   // ==========================================================
   // transmit path: accept issued ahead of the frame slot
   localparam int DLY = (WRITE_LATENCY < 1) ? 1 : WRITE_LATENCY;
   logic [3:0] slot_pipe_reg [DLY];
   logic [3:0] accept_prev_reg;
   logic [3:0] take_lanes;

   // zeroes every byte whose lane flag is clear
   function automatic logic [31:0] lane_mask(input logic [3:0] lanes, input logic [31:0] word);
      logic [31:0] res;
      res = diq_pkg::WORD_ZERO;
      for (int b = 0; b < diq_pkg::LANES; b++) begin
         res[b*8 +: 8] = lanes[b] ? word[b*8 +: 8] : 8'h00;
      end
      return res;
   endfunction : lane_mask

   // frame position counters are left to the auxiliary port
   assign take_lanes = accept_prev_reg & tx_sample_lane_flags;
   always_ff @(posedge sys_clk) begin
      if (srst || !ENABLE) begin
         tx_sample_lane_accept <= diq_pkg::LANES_NONE;
         accept_prev_reg <= diq_pkg::LANES_NONE;
      end else begin
         tx_sample_lane_accept <= frm_tx_slot_lanes;
         accept_prev_reg <= tx_sample_lane_accept;
      end
   end

   // write latency delays the inserted bytes toward the frame
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int i = 0; i < DLY; i++) begin
            slot_pipe_reg[i] <= diq_pkg::LANES_NONE;
         end
      end else begin
         slot_pipe_reg[0] <= take_lanes;
         for (int i = 1; i < DLY; i++) begin
            slot_pipe_reg[i] <= slot_pipe_reg[i-1];
         end
      end
   end

   logic [31:0] word_pipe_reg [DLY];
   genvar g;
   generate
      for (g = 0; g < DLY; g++) begin : g_wpipe
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               word_pipe_reg[g] <= diq_pkg::WORD_ZERO;
            end else if (g == 0) begin
               word_pipe_reg[g] <= lane_mask(take_lanes, tx_sample_word);
            end else begin
               word_pipe_reg[g] <= word_pipe_reg[(g == 0) ? 0 : g-1];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         frm_tx_lane_flags <= diq_pkg::LANES_NONE;
         frm_tx_word <= diq_pkg::WORD_ZERO;
      end else begin
         frm_tx_lane_flags <= slot_pipe_reg[DLY-1];
         frm_tx_word <= word_pipe_reg[DLY-1];
      end
   end

   // ==========================================================
   // checks
   a_accept_follows_slot: assert property (@(posedge sys_clk) disable iff (srst)
      ENABLE |=> tx_sample_lane_accept == $past(frm_tx_slot_lanes))
      else $error("accept does not follow slot schedule");
   a_lane_ignored: assert property (@(posedge sys_clk) disable iff (srst)
      (tx_sample_lane_accept == 4'h0) |=> ##1 slot_pipe_reg[0] == 4'h0)
      else $error("lane taken without prior accept");
   a_insert_latency: assert property (@(posedge sys_clk) disable iff (srst)
      ##(DLY+2) frm_tx_lane_flags ==
      $past(take_lanes, DLY+1))
      else $error("inserted lanes wrong");
   a_rx_no_overflow: assert property (@(posedge sys_clk) disable iff (srst)
      buf_cnt_reg <= 2'h2)
      else $error("receive buffer overflow");
   a_rx_hold_stall: assert property (@(posedge sys_clk) disable iff (srst)
      (rx_sample_lane_flags != 4'h0 && !rx_sample_ready) |=>
      $stable(rx_sample_word) && $stable(rx_sample_lane_flags))
      else $error("receive word changed under stall");
   a_rx_empty_quiet: assert property (@(posedge sys_clk) disable iff (srst)
      (buf_cnt_reg == 2'h0) |-> rx_sample_lane_flags == 4'h0)
      else $error("flags shown with empty buffer");
   a_rx_take_flags: assert property (@(posedge sys_clk) disable iff (srst)
      (in_fire && buf_cnt_reg == 2'h0) |=> rx_sample_lane_flags == $past(frm_rx_lane_flags))
      else $error("taken flags not presented");
   a_rx_take_word: assert property (@(posedge sys_clk) disable iff (srst)
      (in_fire && buf_cnt_reg == 2'h0) |=> rx_sample_word == $past(frm_rx_word))
      else $error("taken word not presented");
   a_rx_ready_room: assert property (@(posedge sys_clk) disable iff (srst)
      (ENABLE && cnt_next != 2'h2) |=> frm_rx_ready)
      else $error("ready low with room left");
   a_tx_word_zeroed: assert property (@(posedge sys_clk) disable iff (srst)
      frm_tx_word == lane_mask(frm_tx_lane_flags, frm_tx_word))
      else $error("byte outside inserted lanes");
   a_disabled_quiet: assert property (@(posedge sys_clk) disable iff (srst)
      !ENABLE |=> tx_sample_lane_accept == 4'h0 && rx_sample_lane_flags == 4'h0)
      else $error("port active while disabled");
   a_ready_full: assert property (@(posedge sys_clk) disable iff (srst)
      (buf_cnt_reg == 2'h2 && !out_fire) |=> !frm_rx_ready)
      else $error("ready high while buffer full");
   a_word_masked: assert property (@(posedge sys_clk) disable iff (srst)
      (accept_prev_reg[0] == 1'b0) |=> word_pipe_reg[0][7:0] == 8'h00)
      else $error("unaccepted byte inserted");
   c_rx_stall: cover property (@(posedge sys_clk) buf_cnt_reg == 2'h2);
   c_tx_full: cover property (@(posedge sys_clk) slot_pipe_reg[0] == 4'hF);
   c_tx_partial: cover property (@(posedge sys_clk) slot_pipe_reg[0] == 4'h7);
   c_rx_pass: cover property (@(posedge sys_clk) in_fire && out_fire);
   c_tx_masked: cover property (@(posedge sys_clk) (tx_sample_lane_flags & ~accept_prev_reg) != 4'h0);
endmodule : diq_slot_port

/* File: rtl/diq_pkg.sv */
package diq_pkg;
   // ==========================================================
   // port geometry
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int WORD_W = LANES * LANE_W;
   // ==========================================================
   // timing, buffer depth and empty values
   localparam int READY_LATENCY = 1;
   localparam int WRITE_LATENCY_DEF = 1;
   localparam int WRITE_LATENCY_MAX = 8;
   localparam int BUF_DEPTH = 2;
   localparam logic [3:0] LANES_NONE = 4'h0;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage : diq_pkg

/* File: sim/diq_user_model.sv */
`timescale 1ns/100ps
// ==========================================
// user-side sample mapper
module diq_user_model (
   input wire logic sys_clk,
   input wire logic [3:0] tx_sample_lane_accept,
   output logic [3:0] tx_sample_lane_flags,
   output logic [31:0] tx_sample_word,
   output logic rx_sample_ready,
   input wire logic stall,
   input wire logic rogue
);
   int seed = 32'h45B7D1D1;
   initial begin
      tx_sample_lane_flags = 4'h0;
      tx_sample_word = 32'h0;
      rx_sample_ready = 1'b0;
   end
   always @(posedge sys_clk) begin
      // fills every lane accepted last cycle; rogue adds lanes never offered
      tx_sample_lane_flags <= tx_sample_lane_accept | (rogue ? 4'($random(seed)) : 4'h0);
      // fresh garbage each cycle so stale bytes never pass as data
      tx_sample_word <= $random(seed);
      rx_sample_ready <= !stall;
   end
endmodule : diq_user_model

/* File: sim/tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
   localparam int WL = 2;
   logic sys_clk, srst, frm_rx_ready, rx_sample_ready, stall, rogue;
   logic [3:0] frm_rx_lane_flags, frm_tx_slot_lanes, frm_tx_lane_flags, rx_sample_lane_flags;
   logic [3:0] tx_sample_lane_accept, tx_sample_lane_flags, slot_d, slot_dd;
   logic [3:0] off_acc, off_rxf;
   logic off_rx_ready;
   logic [35:0] rx_exp;
   logic [31:0] frm_rx_word, frm_tx_word, rx_sample_word, tx_sample_word;
   logic [35:0] tq [0:WL];
   logic [35:0] rxq [$];
   int err_total = 0, cmp_count = 0, mode = 0, seed = 32'h45B7D1D1;
   // ==========================================
   // design and partner
   diq_slot_port #(.WRITE_LATENCY(WL)) i_dut (.sys_clk, .srst, .frm_rx_lane_flags, .frm_rx_word,
      .frm_rx_ready, .frm_tx_slot_lanes, .frm_tx_lane_flags, .frm_tx_word, .rx_sample_lane_flags,
      .rx_sample_word, .rx_sample_ready, .tx_sample_lane_accept, .tx_sample_lane_flags,
      .tx_sample_word);
   diq_slot_port #(.ENABLE(1'b0)) i_off (.sys_clk, .srst, .frm_rx_lane_flags, .frm_rx_word,
      .frm_rx_ready(off_rx_ready), .frm_tx_slot_lanes, .frm_tx_lane_flags(), .frm_tx_word(),
      .rx_sample_lane_flags(off_rxf), .rx_sample_word(), .rx_sample_ready,
      .tx_sample_lane_accept(off_acc), .tx_sample_lane_flags, .tx_sample_word);
   diq_user_model i_user (.sys_clk, .tx_sample_lane_accept, .tx_sample_lane_flags,
      .tx_sample_word, .rx_sample_ready, .stall, .rogue);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] msk(logic [3:0] f, logic [31:0] w);
      for (int i = 0; i < 4; i++) msk[8*i+:8] = f[i] ? w[8*i+:8] : 8'h00;
   endfunction : msk
   task automatic close_out;
      $display("%0d mismatches, %0d comparisons", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   // ==========================================
   // scoreboards
   always @(posedge sys_clk) begin
      slot_d <= srst ? 4'h0 : frm_tx_slot_lanes;
      slot_dd <= srst ? 4'h0 : slot_d;
      if (srst) begin
         for (int i = 0; i <= WL; i++) tq[i] <= 36'h0;
      end else begin
         `CHK(tx_sample_lane_accept, slot_d)
         `CHK({frm_tx_lane_flags, frm_tx_word}, tq[WL])
         `CHK({off_acc, off_rxf, off_rx_ready}, 9'h000)
         for (int i = WL; i > 0; i--) tq[i] <= tq[i-1];
         // a lane counts only when accepted last cycle and flagged now
         tq[0] <= {slot_dd & tx_sample_lane_flags,
            msk(slot_dd & tx_sample_lane_flags, tx_sample_word)};
         if (frm_rx_lane_flags != 4'h0 && frm_rx_ready)
            rxq.push_back({frm_rx_lane_flags, msk(frm_rx_lane_flags, frm_rx_word)});
         if (rx_sample_lane_flags != 4'h0 && rx_sample_ready) begin
            `CHK(rxq.size() > 0, 1'b1)
            if (rxq.size() > 0) begin
               rx_exp = rxq.pop_front();
               `CHK({rx_sample_lane_flags, msk(rx_sample_lane_flags, rx_sample_word)}, rx_exp)
            end
         end
      end
   end
   // ==========================================
   // stimulus: 0 random, 1 full slots, 2 receiver stalled, 3 rogue lanes, 4 drain
   initial begin
      srst = 1'b1;
      stall = 1'b0;
      rogue = 1'b0;
      frm_rx_lane_flags = 4'h0;
      frm_rx_word = 32'h0;
      frm_tx_slot_lanes = 4'h0;
      repeat (12) @(posedge sys_clk);
      `CHK({rx_sample_lane_flags, frm_tx_lane_flags}, 8'h00)
      srst <= 1'b0;
      for (mode = 0; mode < 5; mode++) begin
         repeat (400) begin
            @(posedge sys_clk);
            frm_tx_slot_lanes <= (mode == 1) ? 4'hF : 4'($random(seed));
            frm_rx_lane_flags <= (mode == 4) ? 4'h0 : 4'($random(seed));
            frm_rx_word <= $random(seed);
            stall <= mode == 2 || (mode != 4 && ($random(seed) & 3) == 0);
            rogue <= mode == 3;
         end
         #1;
         if (mode == 2) `CHK(frm_rx_ready, 1'b0)
         $display("test %0d done, %0d checks", mode, cmp_count);
      end
      `CHK(rxq.size(), 0)
      close_out;
   end
   initial begin
      #(25.0 * 5000);
      err_total++;
      close_out;
   end
endmodule : tb
